// ===== rtl/smc_pkg.sv
package smc_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_CS0 = 8'h10;
    localparam logic [7:0] OFS_CS1 = 8'h14;
    localparam logic [7:0] OFS_CS2 = 8'h18;
    localparam logic [7:0] OFS_CS3 = 8'h1C;
    localparam logic [7:0] OFS_DMA_TMO = 8'h28;

    // Reset values
    localparam logic [31:0] CS_RESET_WORD = 32'h0010_FFFF;
    localparam logic [7:0] DMA_TMO_RESET = 8'h00;

    // Bits 19 and 3 of a chip-select word are not writable
    localparam logic [31:0] CS_WRITE_MASK = 32'hFFF7_FFF7;

    // Read-mode codes
    localparam logic [2:0] RDM_ASYNC = 3'h0;
    localparam logic [2:0] RDM_PAGE4 = 3'h1;
    localparam logic [2:0] RDM_PAGE8 = 3'h2;
    localparam logic [2:0] RDM_PAGE16 = 3'h3;
    localparam logic [2:0] RDM_SYNC4 = 3'h4;
    localparam logic [2:0] RDM_SYNC5 = 3'h5;
    localparam logic [2:0] RDM_RSVD = 3'h6;
    localparam logic [2:0] RDM_SYNC7 = 3'h7;

    // Words per page in page ROM modes
    localparam logic [4:0] PAGE_WORDS_4 = 5'h04;
    localparam logic [4:0] PAGE_WORDS_8 = 5'h08;
    localparam logic [4:0] PAGE_WORDS_16 = 5'h10;
    localparam logic [4:0] PAGE_WORDS_NONE = 5'h00;

    // Reference clock divide ratios for codes 00, 01, 10, 11
    localparam logic [2:0] DIV_RATIO_0 = 3'h1;
    localparam logic [2:0] DIV_RATIO_1 = 3'h2;
    localparam logic [2:0] DIV_RATIO_2 = 3'h4;
    localparam logic [2:0] DIV_RATIO_3 = 3'h6;

    // Strobe length of a read access, in reference cycles
    localparam logic [3:0] READ_STROBE_LEN = 4'h1;

    typedef struct packed {
        logic page_wait_source_select;
        logic [3:0] page_wait_count;
        logic [3:0] turnaround_idle_count;
        logic muxed_addr_data_enable;
        logic rsvd_zero;
        logic bus_width_select;
        logic rsvd_read_mode_select_ext;
        logic [2:0] read_mode_select;
        logic [3:0] write_strobe_length;
        logic [3:0] write_wait_count;
        logic [3:0] read_wait_count;
        logic rsvd_one;
        logic read_retime_enable;
        logic [1:0] ref_clock_divider;
    } smc_cs_cfg_s;

    typedef struct packed {
        logic [3:0] lead;
        logic [3:0] strobe;
        logic [3:0] idle;
        logic [1:0] div;
    } smc_timing_s;

    typedef enum logic [3:0] {
        PH_IDLE = 4'h1,
        PH_LEAD = 4'h2,
        PH_STROBE = 4'h4,
        PH_TURN = 4'h8
    } smc_phase_e;

endpackage

// ===== rtl/smc_cs_timing.sv
`timescale 1ns/1ps
`default_nettype none

module smc_cs_timing
    import smc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire smc_timing_s tim_i,
    output logic ref_tick_o,
    output smc_phase_e phase_o,
    output logic done_o
);

    logic [2:0] div_cnt_reg;
    logic [2:0] ratio;
    smc_timing_s tim_reg;
    smc_phase_e phase_reg;
    logic [3:0] cnt_reg;
    logic done_reg;

    always_comb begin
        case (tim_reg.div)
            2'h0: ratio = DIV_RATIO_0;
            2'h1: ratio = DIV_RATIO_1;
            2'h2: ratio = DIV_RATIO_2;
            default: ratio = DIV_RATIO_3;
        endcase
    end

    // Free-running divider; ticks mark reference clock cycles
    always_ff @(posedge clk_i) begin
        if (rst_i || ref_tick_o) begin
            div_cnt_reg <= 3'h0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 3'h1;
        end
    end

    assign ref_tick_o = (div_cnt_reg >= ratio - 3'h1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tim_reg <= '0;
        end else if (start_i && phase_reg == PH_IDLE) begin
            tim_reg <= tim_i;
        end
    end

    // Lead, strobe and turnaround each end on the tick that finds their count at zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_reg <= PH_IDLE;
            cnt_reg <= 4'h0;
        end else begin
            case (phase_reg)
                PH_IDLE: begin
                    if (start_i) begin
                        phase_reg <= PH_LEAD;
                        cnt_reg <= tim_i.lead;
                    end
                end
                PH_LEAD: begin
                    if (ref_tick_o && cnt_reg == 4'h0) begin
                        phase_reg <= PH_STROBE;
                        cnt_reg <= (tim_reg.strobe == 4'h0) ? 4'h0 : tim_reg.strobe - 4'h1;
                    end else if (ref_tick_o) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                PH_STROBE: begin
                    if (ref_tick_o && cnt_reg == 4'h0) begin
                        phase_reg <= PH_TURN;
                        cnt_reg <= tim_reg.idle;
                    end else if (ref_tick_o) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                PH_TURN: begin
                    if (ref_tick_o && cnt_reg == 4'h0) begin
                        phase_reg <= PH_IDLE;
                    end else if (ref_tick_o) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                default: begin
                    phase_reg <= PH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= (phase_reg == PH_TURN) && ref_tick_o && cnt_reg == 4'h0;
        end
    end

    assign phase_o = phase_reg;
    assign done_o = done_reg;

endmodule // smc_cs_timing

`default_nettype wire

// ===== rtl/smc_static_mem_cs_timing.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Page wait comes from bits 15:12 when source select is 0, else bits 30:27.
// - With source select set, in-page waits use the dedicated 4-bit field.
// - Bits 15:12 set write-strobe length, and page wait when source select is 0.
// - With source select set, bits 15:12 only set the write-strobe length.
// - Bits 26:23 set idle cycles for turnaround and chip-select high time.
// - Bit 22 chooses plain (0) or multiplexed (1) address and data.
// - Bit 20 picks 16-bit (0) or 32-bit (1) bus; resets to 1.
// - Bit 19 is read-only and its read value is not to be relied on.
// - Read mode 000 is plain asynchronous reads and the reset default.
// - Read modes 001, 010, 011 are page ROM with 4, 8, 16 words.
// - Read modes 100, 101 and 111 are synchronous burst reads.
// - Bits 11:8 set the write wait cycles.
// - Bits 7:4 set async read waits and initial page or sync read latency.
// - Bit 3 resets to 1, ignores writes, reads undefined.
// - Retiming only allowed in read modes 4, 5 and 7.
// - Bits 1:0 divide the controller clock by 1, 2, 4 or 6.
// - Chip selects 0 and 3 take reset words captured at reset release.
// - Time-out register holds an 8-bit cycle count; upper bits reset zero.
// - A DMA request pending for the programmed count becomes high priority.
module smc_static_mem_cs_timing
    import smc_pkg::*;
#(
    parameter int NUM_CS = 4,
    parameter int ADR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [31:0] boot_cs0_word_i,
    input wire logic [31:0] boot_cs3_word_i,
    input wire logic acc_valid_i,
    output logic acc_ready_o,
    input wire logic [1:0] acc_cs_i,
    input wire logic acc_write_i,
    input wire logic acc_in_page_i,
    output logic acc_done_o,
    output logic [NUM_CS-1:0] mem_cs_n_o,
    output logic mem_we_n_o,
    output logic mem_oe_n_o,
    output logic mem_ref_tick_o,
    output logic mem_muxed_o,
    output logic mem_bus32_o,
    output logic [4:0] mem_page_words_o,
    output logic mem_sync_burst_o,
    output logic mem_retime_o,
    input wire logic dma_req_pending_i,
    output logic dma_high_prio_o
);

    smc_cs_cfg_s cfg_reg [NUM_CS];
    logic [7:0] dma_tmo_reg;
    logic [7:0] dma_wait_reg;
    logic boot_load_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic bus_req;
    logic [31:0] byte_mask;
    logic [1:0] active_cs_reg;
    logic active_write_reg;
    logic launch;
    smc_cs_cfg_s sel_cfg;
    smc_timing_s sel_tim;
    logic [3:0] page_wait;
    logic page_mode;
    logic sync_mode;
    logic muxed_reg;
    logic bus32_reg;
    logic [4:0] page_words_reg;
    logic sync_burst_reg;
    logic retime_reg;
    logic [NUM_CS-1:0] start;
    logic [NUM_CS-1:0] tick;
    logic [NUM_CS-1:0] done;
    logic [NUM_CS-1:0] eng_idle;
    smc_phase_e phase [NUM_CS];

    // ---- Wishbone slave ----

    assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            byte_mask[b*8 +: 8] = {8{wb_sel_i[b]}};
        end
    end

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req;
        end
    end

    // Unmapped offsets answer with zero and ignore writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            if (wb_adr_i == ADR_W'(OFS_CS0)) begin
                rdata_reg <= cfg_reg[0];
            end else if (wb_adr_i == ADR_W'(OFS_CS1)) begin
                rdata_reg <= cfg_reg[1];
            end else if (wb_adr_i == ADR_W'(OFS_CS2)) begin
                rdata_reg <= cfg_reg[2];
            end else if (wb_adr_i == ADR_W'(OFS_CS3)) begin
                rdata_reg <= cfg_reg[3];
            end else if (wb_adr_i == ADR_W'(OFS_DMA_TMO)) begin
                rdata_reg <= {24'h00_0000, dma_tmo_reg};
            end else begin
                rdata_reg <= 32'h0000_0000;
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // ---- Configuration words ----

    // Boot capture happens on the first edge after release, so a strap
    // never reaches a flop through the reset branch.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            boot_load_reg <= 1'b1;
        end else begin
            boot_load_reg <= 1'b0;
        end
    end

    function automatic smc_cs_cfg_s merge_cfg(input smc_cs_cfg_s old_cfg, input logic [31:0] wdat,
                                              input logic [31:0] bmask);
        logic [31:0] m;
        m = bmask & CS_WRITE_MASK;
        merge_cfg = (old_cfg & ~m) | (wdat & m);
    endfunction

    function automatic smc_cs_cfg_s boot_cfg(input logic [31:0] word);
        smc_cs_cfg_s c;
        c = word;
        c.rsvd_read_mode_select_ext = 1'b0;
        c.rsvd_one = 1'b1;
        boot_cfg = c;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_CS; i++) begin
                cfg_reg[i] <= CS_RESET_WORD;
            end
        end else if (boot_load_reg) begin
            cfg_reg[0] <= boot_cfg(boot_cs0_word_i);
            cfg_reg[3] <= boot_cfg(boot_cs3_word_i);
        end else if (bus_req && wb_we_i) begin
            if (wb_adr_i == ADR_W'(OFS_CS0)) begin
                cfg_reg[0] <= merge_cfg(cfg_reg[0], wb_dat_i, byte_mask);
            end else if (wb_adr_i == ADR_W'(OFS_CS1)) begin
                cfg_reg[1] <= merge_cfg(cfg_reg[1], wb_dat_i, byte_mask);
            end else if (wb_adr_i == ADR_W'(OFS_CS2)) begin
                cfg_reg[2] <= merge_cfg(cfg_reg[2], wb_dat_i, byte_mask);
            end else if (wb_adr_i == ADR_W'(OFS_CS3)) begin
                cfg_reg[3] <= merge_cfg(cfg_reg[3], wb_dat_i, byte_mask);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dma_tmo_reg <= DMA_TMO_RESET;
        end else if (bus_req && wb_we_i && wb_adr_i == ADR_W'(OFS_DMA_TMO) && wb_sel_i[0]) begin
            dma_tmo_reg <= wb_dat_i[7:0];
        end
    end

    // ---- DMA priority time-out ----

    // Saturates so a long wait cannot wrap back to low priority
    always_ff @(posedge clk_i) begin
        if (rst_i || !dma_req_pending_i) begin
            dma_wait_reg <= 8'h00;
        end else if (dma_wait_reg != 8'hFF) begin
            dma_wait_reg <= dma_wait_reg + 8'h01;
        end
    end

    assign dma_high_prio_o = dma_req_pending_i && (dma_wait_reg >= dma_tmo_reg);

    // ---- Access timing selection ----

    assign sel_cfg = cfg_reg[acc_cs_i];

    always_comb begin
        page_wait = sel_cfg.page_wait_source_select ? sel_cfg.page_wait_count
                                                    : sel_cfg.write_strobe_length;
        page_mode = (sel_cfg.read_mode_select == RDM_PAGE4) ||
                    (sel_cfg.read_mode_select == RDM_PAGE8) ||
                    (sel_cfg.read_mode_select == RDM_PAGE16);
        sync_mode = (sel_cfg.read_mode_select == RDM_SYNC4) ||
                    (sel_cfg.read_mode_select == RDM_SYNC5) ||
                    (sel_cfg.read_mode_select == RDM_SYNC7);
    end

    always_comb begin
        sel_tim.div = sel_cfg.ref_clock_divider;
        sel_tim.idle = sel_cfg.turnaround_idle_count;
        if (acc_write_i) begin
            sel_tim.lead = sel_cfg.write_wait_count;
            sel_tim.strobe = sel_cfg.write_strobe_length;
        end else if (acc_in_page_i && page_mode) begin
            sel_tim.lead = page_wait;
            sel_tim.strobe = READ_STROBE_LEN;
        end else begin
            sel_tim.lead = sel_cfg.read_wait_count;
            sel_tim.strobe = READ_STROBE_LEN;
        end
    end

    assign acc_ready_o = &eng_idle;
    assign launch = acc_valid_i && acc_ready_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_cs_reg <= 2'h0;
            active_write_reg <= 1'b0;
        end else if (launch) begin
            active_cs_reg <= acc_cs_i;
            active_write_reg <= acc_write_i;
        end
    end

    // Protocol outputs held for the whole access
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            muxed_reg <= 1'b0;
            bus32_reg <= 1'b0;
            page_words_reg <= PAGE_WORDS_NONE;
            sync_burst_reg <= 1'b0;
            retime_reg <= 1'b0;
        end else if (launch) begin
            muxed_reg <= sel_cfg.muxed_addr_data_enable;
            bus32_reg <= sel_cfg.bus_width_select;
            sync_burst_reg <= sync_mode;
            // Retime is suppressed outside burst modes instead of hanging
            retime_reg <= sel_cfg.read_retime_enable && sync_mode;
            case (sel_cfg.read_mode_select)
                RDM_PAGE4: page_words_reg <= PAGE_WORDS_4;
                RDM_PAGE8: page_words_reg <= PAGE_WORDS_8;
                RDM_PAGE16: page_words_reg <= PAGE_WORDS_16;
                default: page_words_reg <= PAGE_WORDS_NONE;
            endcase
        end
    end

    // ---- Per chip-select timing engines ----

    genvar g;
    generate
        for (g = 0; g < NUM_CS; g++) begin : g_cs
            assign start[g] = launch && (acc_cs_i == 2'(g));
            assign eng_idle[g] = (phase[g] == PH_IDLE);
            // Chip select goes high during turnaround for its minimum high time
            assign mem_cs_n_o[g] = !((phase[g] == PH_LEAD) || (phase[g] == PH_STROBE));

            smc_cs_timing u_timing (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .start_i(start[g]),
                .tim_i(sel_tim),
                .ref_tick_o(tick[g]),
                .phase_o(phase[g]),
                .done_o(done[g])
            );
        end
    endgenerate

    assign acc_done_o = |done;
    assign mem_ref_tick_o = tick[active_cs_reg];
    assign mem_we_n_o = !(active_write_reg && phase[active_cs_reg] == PH_STROBE);
    assign mem_oe_n_o = !(!active_write_reg && !eng_idle[active_cs_reg] &&
                          phase[active_cs_reg] != PH_TURN);
    assign mem_muxed_o = muxed_reg;
    assign mem_bus32_o = bus32_reg;
    assign mem_page_words_o = page_words_reg;
    assign mem_sync_burst_o = sync_burst_reg;
    assign mem_retime_o = retime_reg;

endmodule // smc_static_mem_cs_timing

`default_nettype wire

// ===== tb/smc_static_mem_cs_timing_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module smc_static_mem_cs_timing_monitor
    import smc_pkg::*;
#(
    parameter int NUM_CS = 4,
    parameter int ADR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic acc_valid_i,
    input wire logic acc_ready_o,
    input wire logic acc_done_o,
    input wire logic [NUM_CS-1:0] mem_cs_n_o,
    input wire logic mem_we_n_o,
    input wire logic mem_oe_n_o,
    input wire logic [4:0] mem_page_words_o,
    input wire logic mem_sync_burst_o,
    input wire logic mem_retime_o,
    input wire logic dma_req_pending_i,
    input wire logic dma_high_prio_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("bus request not answered next cycle");
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held over one cycle");
    property p_launch; acc_valid_i && acc_ready_o |=> !acc_ready_o ##[1:600] acc_done_o; endproperty
    a_launch: assert property (p_launch) else $error("access not busy or not finished in time");
    property p_done_idle; acc_done_o |-> acc_ready_o && (&mem_cs_n_o); endproperty
    a_done_idle: assert property (p_done_idle) else $error("done while pins still active");
    property p_idle_pins; acc_ready_o |-> (&mem_cs_n_o) && mem_we_n_o && mem_oe_n_o; endproperty
    a_idle_pins: assert property (p_idle_pins) else $error("memory pins active while idle");
    property p_we_excl; !mem_we_n_o |-> mem_oe_n_o && $onehot(~mem_cs_n_o); endproperty
    a_we_excl: assert property (p_we_excl) else $error("write strobe with bad select or read enable");
    property p_page_sync; mem_page_words_o != 5'h00 |-> !mem_sync_burst_o; endproperty
    a_page_sync: assert property (p_page_sync) else $error("page and burst mode together");
    property p_retime; mem_retime_o |-> mem_sync_burst_o; endproperty
    a_retime: assert property (p_retime) else $error("retiming outside burst modes");
    property p_prio; dma_high_prio_o |-> dma_req_pending_i; endproperty
    a_prio: assert property (p_prio) else $error("high priority without a pending request");
    property p_prio_drop; $fell(dma_req_pending_i) |-> !dma_high_prio_o; endproperty
    a_prio_drop: assert property (p_prio_drop) else $error("high priority kept after request left");
endmodule // smc_static_mem_cs_timing_monitor

bind smc_static_mem_cs_timing smc_static_mem_cs_timing_monitor #(.NUM_CS(NUM_CS), .ADR_W(ADR_W)) mon_u (.*);
`default_nettype wire

// ===== tb/smc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Memory side: measures strobe and select widths in controller clocks
module smc_mem_model (
    input wire logic clk_i,
    input wire logic [3:0] cs_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    output int we_len_o,
    output int oe_len_o,
    output int cs_len_o
);
    int we_run = 0;
    int oe_run = 0;
    int cs_run = 0;
    always @(posedge clk_i) begin
        if (!we_n_i) we_run <= we_run + 1;
        else if (we_run != 0) begin we_len_o <= we_run; we_run <= 0; end
        if (!oe_n_i) oe_run <= oe_run + 1;
        else if (oe_run != 0) begin oe_len_o <= oe_run; oe_run <= 0; end
        if (!(&cs_n_i)) cs_run <= cs_run + 1;
        else if (cs_run != 0) begin cs_len_o <= cs_run; cs_run <= 0; end
    end
endmodule // smc_mem_model
`default_nettype wire

// ===== tb/smc_static_mem_cs_timing_tb.sv
`timescale 1ns/1ps
`default_nettype none
module smc_static_mem_cs_timing_tb
    import smc_pkg::*;
;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, av = 0, aw = 0, ap = 0, pend = 0;
    logic [7:0] adr = '0;
    logic [31:0] dat = '0, q;
    logic [1:0] acs = '0;
    logic [31:0] wdo;
    logic ack, ardy, adone, we_n, oe_n, tick, mux, b32, sync, rt, prio;
    logic [3:0] cs_n;
    logic [4:0] pw;
    int fail_count = 0, compares = 0, cycles = 0, we_len, oe_len, cs_len, n, a0, b0;
    always #20 clk_i = ~clk_i;

    smc_static_mem_cs_timing dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack),
        .boot_cs0_word_i(32'h1238_4560), .boot_cs3_word_i(32'h0F0F_0F00), .acc_valid_i(av),
        .acc_ready_o(ardy), .acc_cs_i(acs), .acc_write_i(aw), .acc_in_page_i(ap), .acc_done_o(adone),
        .mem_cs_n_o(cs_n), .mem_we_n_o(we_n), .mem_oe_n_o(oe_n), .mem_ref_tick_o(tick),
        .mem_muxed_o(mux), .mem_bus32_o(b32), .mem_page_words_o(pw), .mem_sync_burst_o(sync),
        .mem_retime_o(rt), .dma_req_pending_i(pend), .dma_high_prio_o(prio));
    smc_mem_model mem_u (.clk_i(clk_i), .cs_n_i(cs_n), .we_n_i(we_n), .oe_n_i(oe_n),
        .we_len_o(we_len), .oe_len_o(oe_len), .cs_len_o(cs_len));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin fail_count++; finish_test(); end
    end
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        // Read data and release both belong to the edge that sees ack high
        q = wdo;
        cyc <= 0; stb <= 0; we <= 0;
    endtask
    // Config word; retiming set in read modes 4 to 7 and bit 21 kept zero
    function automatic logic [31:0] mk(input logic ps, input logic [3:0] pg, idl,
        input logic [2:0] md, input logic [3:0] ws, ww, rw, input logic [1:0] dv);
        smc_cs_cfg_s c;
        c = '0;
        c.page_wait_source_select = ps; c.page_wait_count = pg; c.turnaround_idle_count = idl;
        c.bus_width_select = 1; c.read_mode_select = md; c.write_strobe_length = ws;
        c.write_wait_count = ww; c.read_wait_count = rw; c.rsvd_one = 1;
        c.read_retime_enable = md[2]; c.ref_clock_divider = dv;
        return c;
    endfunction
    // Programs chip select 2, runs one access, returns clocks to done
    task automatic acc(input logic [31:0] w, input logic wr, input logic pg, output int k);
        wb(OFS_CS2, 1, w);
        @(posedge clk_i);
        av <= 1; acs <= 2'h2; aw <= wr; ap <= pg;
        @(posedge clk_i);
        av <= 0;
        k = 0;
        do begin @(posedge clk_i); #1 k++; end while (adone !== 1'b1 && k < 800);
        if (k >= 800) begin fail_count++; finish_test(); end
    endtask

    task automatic t_regs();
        wb(OFS_CS1, 0, 0); check(q, 32'h0010_FFFF);
        wb(OFS_CS0, 0, 0); check(q, 32'h1230_4568);
        wb(OFS_CS3, 0, 0); check(q, 32'h0F07_0F08);
        wb(OFS_DMA_TMO, 0, 0); check(q, 32'h0);
        wb(OFS_CS1, 1, 32'hFFDF_FFF7); wb(OFS_CS1, 0, 0); check(q, 32'hFFD7_FFFF);
        wb(OFS_CS1, 1, 32'h0); wb(OFS_CS1, 0, 0); check(q, 32'h0000_0008);
        wb(8'h20, 1, 32'h1234_5678); wb(8'h20, 0, 0); check(q, 32'h0);
        $display("Register test done");
    endtask
    task automatic t_strobe_div();
        logic [2:0] r [4] = '{DIV_RATIO_0, DIV_RATIO_1, DIV_RATIO_2, DIV_RATIO_3};
        for (int d = 0; d < 4; d++) begin
            acc(mk(0, 0, 1, RDM_ASYNC, 3, 2, 2, d[1:0]), 1, 0, n);
            check(we_len, 3 * r[d]);
        end
        $display("Strobe and divider test done");
    endtask
    task automatic t_waits();
        acc(mk(0, 0, 1, RDM_ASYNC, 2, 2, 2, 0), 1, 0, n); a0 = cs_len;
        acc(mk(0, 0, 1, RDM_ASYNC, 2, 6, 2, 0), 1, 0, n); check(cs_len - a0, 4);
        acc(mk(0, 0, 1, RDM_ASYNC, 2, 2, 2, 0), 0, 0, n); a0 = oe_len; b0 = n - cs_len;
        acc(mk(0, 0, 1, RDM_ASYNC, 2, 2, 6, 0), 0, 0, n); check(oe_len - a0, 4);
        acc(mk(0, 0, 5, RDM_ASYNC, 2, 2, 2, 0), 0, 0, n); check(n - cs_len - b0, 4);
        $display("Wait state test done");
    endtask
    task automatic t_page();
        acc(mk(0, 9, 1, RDM_PAGE4, 3, 2, 2, 0), 0, 1, n); a0 = oe_len;
        acc(mk(1, 9, 1, RDM_PAGE4, 3, 2, 2, 0), 0, 1, n); check(oe_len - a0, 6);
        b0 = oe_len;
        acc(mk(1, 9, 1, RDM_PAGE4, 12, 2, 2, 0), 0, 1, n); check(oe_len, b0);
        $display("Page wait test done");
    endtask
    task automatic t_modes();
        logic [31:0] w;
        for (int m = 0; m < 8; m++) begin
            if (m == 6) continue;
            w = mk(0, 0, 1, m[2:0], 2, 2, 2, 0);
            w[22] = m[0];
            w[20] = m[1];
            acc(w, 0, 0, n);
            check(pw, m == 1 ? 5'h04 : m == 2 ? 5'h08 : m == 3 ? 5'h10 : 5'h00);
            check(sync, m[2]);
            check(rt, m[2]);
            check(mux, m[0]);
            check(b32, m[1]);
        end
        $display("Read mode test done");
    endtask
    task automatic t_dma();
        wb(OFS_DMA_TMO, 1, 32'h5); wb(OFS_DMA_TMO, 0, 0); check(q, 32'h5);
        @(posedge clk_i);
        pend <= 1;
        n = 0;
        do begin @(posedge clk_i); #1 n++; end while (prio !== 1'b1 && n < 50);
        check(n, 5);
        @(posedge clk_i);
        pend <= 0;
        @(posedge clk_i); #1 check(prio, 0);
        $display("Priority time-out test done");
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        repeat (2) @(posedge clk_i);
        t_regs();
        t_strobe_div();
        t_waits();
        t_page();
        t_modes();
        t_dma();
        finish_test();
    end
endmodule // smc_static_mem_cs_timing_tb
`default_nettype wire
